// ===== cpusr_pkg.sv
// constants and rule summary for the cpu status word block
// Contract
// R1 - status word is 16 bits; bits 15..9 read zero and ignore writes
// R2 - all other status bits read and write, except repeat flag and locked priority
// R3 - half carry at bit 8: carry out of bit 3 (byte) or bit 7 (word)
// R4 - bits 7..5 hold priority level low bits, 000..111 meaning levels 0..7
// R5 - priority low bits 111 mean level 7 with user interrupts disabled
// R6 - effective level joins top bit from core control bit 3 above low bits
// R7 - top priority bit set blocks all user interrupts whatever the low bits
// R8 - nesting disable set makes priority low bits read-only to software
// R9 - bit 4 repeat active flag follows loop hardware, software cannot write it
// R10 - bit 3 negative flag set on negative result, cleared otherwise
// R11 - bit 2 overflow flag set on signed overflow, cleared otherwise
// R12 - bit 1 zero flag set on zero result, cleared otherwise
// R13 - bit 0 carry flag set on carry out of the top result bit
// R14 - exception entry pushes program counter top byte joined above status low byte
// R15 - for subtraction carry and half carry act as not-borrow indicators
// R16 - byte operations take flags from the low result byte only
// R17 - every implemented status bit clears on reset
// R18 - alu flag update beats a same-cycle software write to that bit
package cpusr_pkg;
   // bus map, byte addresses of 32-bit words
   localparam logic [7:0]  CPUSR_ADR_STATUS   = 8'h00;
   localparam logic [7:0]  CPUSR_ADR_CORECTL  = 8'h04;
   localparam logic [7:0]  CPUSR_ADR_INTCTL1  = 8'h08;
   localparam logic [7:0]  CPUSR_ADR_LEVEL    = 8'h0C;
   // status word and control register field positions
   localparam int          CPUSR_B_CARRY      = 0;
   localparam int          CPUSR_B_ZERO       = 1;
   localparam int          CPUSR_B_OVF        = 2;
   localparam int          CPUSR_B_NEG        = 3;
   localparam int          CPUSR_B_REPEAT     = 4;
   localparam int          CPUSR_B_PRIO_LO    = 5;
   localparam int          CPUSR_B_HALF_CARRY = 8;
   localparam int          CPUSR_B_TOP_PRIO   = 3;
   localparam int          CPUSR_B_NEST_DIS   = 15;
   // flag update mask positions
   localparam int          CPUSR_M_CARRY      = 0;
   localparam int          CPUSR_M_ZERO       = 1;
   localparam int          CPUSR_M_OVF        = 2;
   localparam int          CPUSR_M_NEG        = 3;
   localparam int          CPUSR_M_HALF       = 4;
   // widths, priority limit and reset values
   localparam int          CPUSR_WORD_W       = 16;
   localparam logic [2:0]  CPUSR_PRIO_MAX     = 3'h7;
   localparam logic [2:0]  CPUSR_PRIO_RST     = 3'h0;
   localparam logic        CPUSR_FLAG_RST     = 1'h0;
   localparam logic [15:0] CPUSR_STACK_RST    = 16'h0000;
endpackage

// ===== cpusr_alu_flags.sv
// alu adder with status flag generation for byte and word modes
`timescale 1ns/1ps
module cpusr_alu_flags
   import cpusr_pkg::*;
(
   input  wire logic [15:0] operand_a,
   input  wire logic [15:0] operand_b,
   input  wire logic        carry_in,
   input  wire logic        subtract,
   input  wire logic        byte_mode,
   output logic      [15:0] result,
   output logic             flag_neg,
   output logic             flag_ovf,
   output logic             flag_zero,
   output logic             flag_carry,
   output logic             flag_half
);
   // add two masked operands with carry, one bit wider than the data
   function automatic logic [16:0] add17(input logic [15:0] a, input logic [15:0] b,
                                         input logic cin);
      add17 = {1'b0, a} + {1'b0, b} + {16'h0000, cin};
   endfunction

   logic [15:0] b_eff;
   logic [16:0] sum_word;
   logic [16:0] sum_byte;
   logic [16:0] sum_nib;
   logic        sign_a;
   logic        sign_b;
   logic        sign_r;

   // subtraction adds the inverted operand, so carry out means no borrow
   assign b_eff    = subtract ? ~operand_b : operand_b; // R15
   assign sum_word = add17(operand_a, b_eff, carry_in);
   assign sum_byte = add17({8'h00, operand_a[7:0]}, {8'h00, b_eff[7:0]}, carry_in);
   assign sum_nib  = add17({12'h000, operand_a[3:0]}, {12'h000, b_eff[3:0]}, carry_in);
   assign result   = sum_word[15:0];

   // flag selection by data size, byte mode looks only at the low byte
   always_comb
   begin
      sign_a    = byte_mode ? operand_a[7] : operand_a[15]; // R16
      sign_b    = byte_mode ? b_eff[7] : b_eff[15];
      sign_r    = byte_mode ? sum_word[7] : sum_word[15];
      flag_neg  = sign_r; // R10
      flag_ovf  = (sign_a == sign_b) && (sign_r != sign_a); // R11
      flag_zero = byte_mode ? (sum_word[7:0] == 8'h00) : (sum_word[15:0] == 16'h0000); // R12
      flag_carry = byte_mode ? sum_byte[8] : sum_word[16]; // R13
      flag_half = byte_mode ? sum_nib[4] : sum_byte[8]; // R3
   end

endmodule

// ===== cpusr_status.sv
// cpu status word with wishbone access, alu flag updates and exception stacking
//
// The Wishbone interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
module cpusr_status
   import cpusr_pkg::*;
(
   input  wire logic        SYS_CLK,
   input  wire logic        RST_N,
   input  wire logic        CYC_I,
   input  wire logic        STB_I,
   input  wire logic        WE_I,
   input  wire logic [7:0]  ADR_I,
   input  wire logic [3:0]  SEL_I,
   input  wire logic [31:0] DAT_I,
   output logic      [31:0] DAT_O,
   output logic             ACK_O,
   input  wire logic        ALU_UPDATE,
   input  wire logic [4:0]  ALU_FLAG_MASK,
   input  wire logic        ALU_SUBTRACT,
   input  wire logic        ALU_USE_CARRY,
   input  wire logic        ALU_BYTE_MODE,
   input  wire logic [15:0] ALU_OPERAND_A,
   input  wire logic [15:0] ALU_OPERAND_B,
   output logic      [15:0] ALU_RESULT,
   input  wire logic        REPEAT_ACTIVE,
   input  wire logic        EXC_ENTRY,
   input  wire logic [7:0]  PC_TOP_BYTE,
   input  wire logic [3:0]  EXC_PRIORITY,
   output logic      [15:0] STACK_WORD,
   output logic             STACK_WORD_VALID,
   output logic      [15:0] STATUS_WORD,
   output logic      [3:0]  PRIORITY_LEVEL,
   output logic             USER_INT_DISABLE
);
   // status fields
   logic        carry_flag;
   logic        zero_flag;
   logic        signed_overflow_flag;
   logic        negative_flag;
   logic        repeat_active_flag;
   logic [2:0]  priority_level_low_bits;
   logic        half_carry_flag;
   logic        priority_level_top_bit;
   logic        nesting_disable_bit;
   // alu outputs
   logic [15:0] alu_sum;
   logic        alu_neg;
   logic        alu_ovf;
   logic        alu_zero;
   logic        alu_carry;
   logic        alu_half;
   logic        alu_cin;
   // bus decode
   logic        bus_req;
   logic        wr_now;
   logic        wr_status;
   logic        wr_lo;
   logic        wr_hi;
   logic [31:0] next_dat;

   // status word image, unimplemented upper bits tied low
   assign STATUS_WORD = {7'h00, half_carry_flag, priority_level_low_bits, repeat_active_flag,
                         negative_flag, signed_overflow_flag, zero_flag, carry_flag}; // R1

   // effective level and user interrupt block
   assign PRIORITY_LEVEL   = {priority_level_top_bit, priority_level_low_bits}; // R6
   assign USER_INT_DISABLE = priority_level_top_bit // R7
                             || (priority_level_low_bits == CPUSR_PRIO_MAX); // R5

   // carry chain input: previous carry for extended ops, else 1 for subtract
   assign alu_cin = ALU_USE_CARRY ? carry_flag : ALU_SUBTRACT;

   cpusr_alu_flags u_alu (
      .operand_a  (ALU_OPERAND_A),
      .operand_b  (ALU_OPERAND_B),
      .carry_in   (alu_cin),
      .subtract   (ALU_SUBTRACT),
      .byte_mode  (ALU_BYTE_MODE),
      .result     (alu_sum),
      .flag_neg   (alu_neg),
      .flag_ovf   (alu_ovf),
      .flag_zero  (alu_zero),
      .flag_carry (alu_carry),
      .flag_half  (alu_half)
   );

   // bus decode: writes commit on the edge where ack is high
   assign bus_req   = CYC_I && STB_I;
   assign wr_now    = bus_req && WE_I && ACK_O;
   assign wr_status = wr_now && (ADR_I == CPUSR_ADR_STATUS);
   assign wr_lo     = wr_status && SEL_I[0];
   assign wr_hi     = wr_status && SEL_I[1];

   // single wait state acknowledge, dropped the cycle after it is given
   always_ff @(posedge SYS_CLK or negedge RST_N)
   begin
      if (!RST_N)
         ACK_O <= 1'b0;
      else
         ACK_O <= bus_req && !ACK_O;
   end

   // read multiplexer, unmapped addresses read zero
   always_comb
   begin
      unique case (ADR_I)
         CPUSR_ADR_STATUS:  next_dat = {16'h0000, STATUS_WORD}; // R1
         CPUSR_ADR_CORECTL: next_dat = {28'h0000000, priority_level_top_bit, 3'h0};
         CPUSR_ADR_INTCTL1: next_dat = {16'h0000, nesting_disable_bit, 15'h0000};
         CPUSR_ADR_LEVEL:   next_dat = {27'h0000000, USER_INT_DISABLE, PRIORITY_LEVEL};
         default:           next_dat = 32'h00000000;
      endcase
   end

   // read data register, loaded with the acknowledge
   always_ff @(posedge SYS_CLK or negedge RST_N)
   begin
      if (!RST_N)
         DAT_O <= 32'h00000000;
      else if (bus_req && !ACK_O && !WE_I)
         DAT_O <= next_dat;
      else if (!bus_req)
         DAT_O <= 32'h00000000;
   end

   // alu result register
   always_ff @(posedge SYS_CLK or negedge RST_N)
   begin
      if (!RST_N)
         ALU_RESULT <= 16'h0000;
      else if (ALU_UPDATE)
         ALU_RESULT <= alu_sum;
   end

   // arithmetic flags: alu update wins, else software lane write, else hold
   always_ff @(posedge SYS_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         carry_flag           <= CPUSR_FLAG_RST; // R17
         zero_flag            <= CPUSR_FLAG_RST;
         signed_overflow_flag <= CPUSR_FLAG_RST;
         negative_flag        <= CPUSR_FLAG_RST;
         half_carry_flag      <= CPUSR_FLAG_RST;
      end
      else
      begin
         if (ALU_UPDATE && ALU_FLAG_MASK[CPUSR_M_CARRY])
            carry_flag <= alu_carry; // R18 R13
         else if (wr_lo)
            carry_flag <= DAT_I[CPUSR_B_CARRY]; // R2
         if (ALU_UPDATE && ALU_FLAG_MASK[CPUSR_M_ZERO])
            zero_flag <= alu_zero; // R12
         else if (wr_lo)
            zero_flag <= DAT_I[CPUSR_B_ZERO];
         if (ALU_UPDATE && ALU_FLAG_MASK[CPUSR_M_OVF])
            signed_overflow_flag <= alu_ovf; // R11
         else if (wr_lo)
            signed_overflow_flag <= DAT_I[CPUSR_B_OVF];
         if (ALU_UPDATE && ALU_FLAG_MASK[CPUSR_M_NEG])
            negative_flag <= alu_neg; // R10
         else if (wr_lo)
            negative_flag <= DAT_I[CPUSR_B_NEG];
         if (ALU_UPDATE && ALU_FLAG_MASK[CPUSR_M_HALF])
            half_carry_flag <= alu_half; // R3
         else if (wr_hi)
            half_carry_flag <= DAT_I[CPUSR_B_HALF_CARRY];
      end
   end

   // repeat flag tracks loop hardware only, software writes have no path
   always_ff @(posedge SYS_CLK or negedge RST_N)
   begin
      if (!RST_N)
         repeat_active_flag <= CPUSR_FLAG_RST;
      else
         repeat_active_flag <= REPEAT_ACTIVE; // R9
   end

   // priority low bits: exception entry wins, software only when nesting enabled
   always_ff @(posedge SYS_CLK or negedge RST_N)
   begin
      if (!RST_N)
         priority_level_low_bits <= CPUSR_PRIO_RST; // R17
      else if (EXC_ENTRY)
         priority_level_low_bits <= EXC_PRIORITY[2:0]; // R4
      else if (wr_lo && !nesting_disable_bit)
         priority_level_low_bits <= DAT_I[CPUSR_B_PRIO_LO +: 3]; // R8
   end

   // top priority bit: set by exception entry, software may only clear it
   always_ff @(posedge SYS_CLK or negedge RST_N)
   begin
      if (!RST_N)
         priority_level_top_bit <= CPUSR_FLAG_RST;
      else if (EXC_ENTRY)
         priority_level_top_bit <= EXC_PRIORITY[3]; // R6
      else if (wr_now && (ADR_I == CPUSR_ADR_CORECTL) && SEL_I[0]
               && !DAT_I[CPUSR_B_TOP_PRIO])
         priority_level_top_bit <= 1'b0;
   end

   // nesting disable control bit
   always_ff @(posedge SYS_CLK or negedge RST_N)
   begin
      if (!RST_N)
         nesting_disable_bit <= CPUSR_FLAG_RST;
      else if (wr_now && (ADR_I == CPUSR_ADR_INTCTL1) && SEL_I[1])
         nesting_disable_bit <= DAT_I[CPUSR_B_NEST_DIS];
   end

   // stacked word on exception entry, taken from the status before the level change
   always_ff @(posedge SYS_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         STACK_WORD       <= CPUSR_STACK_RST;
         STACK_WORD_VALID <= 1'b0;
      end
      else
      begin
         STACK_WORD_VALID <= EXC_ENTRY;
         if (EXC_ENTRY)
            STACK_WORD <= {PC_TOP_BYTE, STATUS_WORD[7:0]}; // R14
      end
   end

   // checks kept beside the logic
   a_upper_zero: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // R1
      (bus_req && !ACK_O && !WE_I && ADR_I == CPUSR_ADR_STATUS) |=> (DAT_O[31:9] == 23'h0))
      else $error("status read shows bits above 8");

   a_sw_writes_flags: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // R2
      (wr_lo && !ALU_UPDATE) |=> (STATUS_WORD[3:0] == $past(DAT_I[3:0])))
      else $error("software write to flags lost");

   a_nest_lock: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // R8
      (wr_lo && nesting_disable_bit && !EXC_ENTRY) |=> $stable(priority_level_low_bits))
      else $error("priority changed while nesting disabled");

   a_repeat_follows: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // R9
      REPEAT_ACTIVE ##1 REPEAT_ACTIVE |-> repeat_active_flag)
      else $error("repeat flag not following loop hardware");

   a_level_block: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // R5
      (PRIORITY_LEVEL[2:0] == 3'h7 || PRIORITY_LEVEL[3]) |-> USER_INT_DISABLE)
      else $error("user interrupts not blocked at high level");

   a_level_open: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // R7
      (!PRIORITY_LEVEL[3] && PRIORITY_LEVEL[2:0] != 3'h7) |-> !USER_INT_DISABLE)
      else $error("user interrupts blocked at low level");

   a_exc_level: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // R6
      EXC_ENTRY |=> (PRIORITY_LEVEL == $past(EXC_PRIORITY)))
      else $error("exception level not loaded");

   a_stack_word: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // R14
      EXC_ENTRY |=> STACK_WORD_VALID && (STACK_WORD[15:8] == $past(PC_TOP_BYTE))
      && (STACK_WORD[7:0] == $past(STATUS_WORD[7:0])))
      else $error("stacked word wrong");

   a_alu_wins: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // R18
      (wr_lo && ALU_UPDATE && ALU_FLAG_MASK[CPUSR_M_ZERO]) |=> (zero_flag == $past(alu_zero)))
      else $error("software write beat alu update");

   a_ack_pulse: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      ACK_O |=> !ACK_O)
      else $error("ack held two cycles");
endmodule

// ===== cpusr_core_model.sv
// behavioural model of the alu, loop control and exception logic facing the status word
`timescale 1ns/1ps
module cpusr_core_model
(
   input  wire logic        SYS_CLK,
   output logic             ALU_UPDATE,
   output logic      [4:0]  ALU_FLAG_MASK,
   output logic             ALU_SUBTRACT,
   output logic             ALU_USE_CARRY,
   output logic             ALU_BYTE_MODE,
   output logic      [15:0] ALU_OPERAND_A,
   output logic      [15:0] ALU_OPERAND_B,
   output logic             REPEAT_ACTIVE,
   output logic             EXC_ENTRY,
   output logic      [7:0]  PC_TOP_BYTE,
   output logic      [3:0]  EXC_PRIORITY
);
   // idle values from time zero
   initial
   begin
      {ALU_UPDATE, ALU_FLAG_MASK, ALU_SUBTRACT, ALU_USE_CARRY, ALU_BYTE_MODE} = '0;
      {ALU_OPERAND_A, ALU_OPERAND_B, REPEAT_ACTIVE, EXC_ENTRY} = '0;
      {PC_TOP_BYTE, EXC_PRIORITY} = '0;
   end
   // one alu operation; mode is use carry, subtract, byte
   task automatic alu_op(input logic [15:0] a, input logic [15:0] b,
                         input logic [4:0] m, input logic [2:0] md);
      @(posedge SYS_CLK);
      {ALU_UPDATE, ALU_OPERAND_A, ALU_OPERAND_B, ALU_FLAG_MASK} <= {1'h1, a, b, m};
      {ALU_USE_CARRY, ALU_SUBTRACT, ALU_BYTE_MODE} <= md;
      @(posedge SYS_CLK);
      ALU_UPDATE <= 1'h0;
      {ALU_OPERAND_A, ALU_OPERAND_B} <= ~{a, b}; // stale operands change
   endtask
   // exception entry, a single cycle pulse with return byte and new level
   task automatic exc(input logic [7:0] pc, input logic [3:0] lvl);
      @(posedge SYS_CLK);
      {EXC_ENTRY, PC_TOP_BYTE, EXC_PRIORITY} <= {1'h1, pc, lvl};
      @(posedge SYS_CLK);
      {EXC_ENTRY, PC_TOP_BYTE} <= {1'h0, ~pc};
   endtask
   // loop control level
   task automatic set_repeat(input logic on);
      @(posedge SYS_CLK);
      REPEAT_ACTIVE <= on;
   endtask
endmodule

// ===== cpusr_status_tb.sv
// self-checking testbench of the cpu status word block
`timescale 1ns/1ps
module cpusr_status_tb
   import cpusr_pkg::*;
;
   logic        SYS_CLK, RST_N, CYC_I, STB_I, WE_I, ACK_O;
   logic [7:0]  ADR_I, PC_TOP_BYTE;
   logic [3:0]  SEL_I, EXC_PRIORITY, PRIORITY_LEVEL;
   logic [31:0] DAT_I, DAT_O, rd;
   logic [4:0]  ALU_FLAG_MASK;
   logic [15:0] ALU_OPERAND_A, ALU_OPERAND_B, ALU_RESULT, STACK_WORD, STATUS_WORD;
   logic        ALU_UPDATE, ALU_SUBTRACT, ALU_USE_CARRY, ALU_BYTE_MODE, REPEAT_ACTIVE;
   logic        EXC_ENTRY, STACK_WORD_VALID, USER_INT_DISABLE;
   int          err_count = 0;
   int          checks = 0;
   int          cycles = 0;
   // alu cases: a, b, mask, mode, expected {half, n, ov, z, c}, expected sum
   localparam logic [60:0] ALU_TBL [6] = '{
      {16'h7FFF, 16'h0001, 5'h1F, 3'h0, 5'h1C, 16'h8000},
      {16'hFFFF, 16'h0001, 5'h1F, 3'h0, 5'h13, 16'h0000},
      {16'h0003, 16'h0005, 5'h1F, 3'h2, 5'h08, 16'hFFFE},
      {16'h12FF, 16'h0001, 5'h1F, 3'h1, 5'h13, 16'h1300},
      {16'h0001, 16'h0001, 5'h02, 3'h0, 5'h11, 16'h0002},
      {16'h0000, 16'h0000, 5'h1F, 3'h4, 5'h00, 16'h0001}};
   cpusr_status i_cpusr_status (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .CYC_I(CYC_I),
      .STB_I(STB_I), .WE_I(WE_I), .ADR_I(ADR_I), .SEL_I(SEL_I), .DAT_I(DAT_I),
      .DAT_O(DAT_O), .ACK_O(ACK_O), .ALU_UPDATE(ALU_UPDATE), .ALU_FLAG_MASK(ALU_FLAG_MASK),
      .ALU_SUBTRACT(ALU_SUBTRACT), .ALU_USE_CARRY(ALU_USE_CARRY),
      .ALU_BYTE_MODE(ALU_BYTE_MODE), .ALU_OPERAND_A(ALU_OPERAND_A),
      .ALU_OPERAND_B(ALU_OPERAND_B), .ALU_RESULT(ALU_RESULT), .REPEAT_ACTIVE(REPEAT_ACTIVE),
      .EXC_ENTRY(EXC_ENTRY), .PC_TOP_BYTE(PC_TOP_BYTE), .EXC_PRIORITY(EXC_PRIORITY),
      .STACK_WORD(STACK_WORD), .STACK_WORD_VALID(STACK_WORD_VALID),
      .STATUS_WORD(STATUS_WORD), .PRIORITY_LEVEL(PRIORITY_LEVEL),
      .USER_INT_DISABLE(USER_INT_DISABLE));
   cpusr_core_model i_cpusr_core_model (.SYS_CLK(SYS_CLK), .ALU_UPDATE(ALU_UPDATE),
      .ALU_FLAG_MASK(ALU_FLAG_MASK), .ALU_SUBTRACT(ALU_SUBTRACT),
      .ALU_USE_CARRY(ALU_USE_CARRY), .ALU_BYTE_MODE(ALU_BYTE_MODE),
      .ALU_OPERAND_A(ALU_OPERAND_A), .ALU_OPERAND_B(ALU_OPERAND_B),
      .REPEAT_ACTIVE(REPEAT_ACTIVE), .EXC_ENTRY(EXC_ENTRY), .PC_TOP_BYTE(PC_TOP_BYTE),
      .EXC_PRIORITY(EXC_PRIORITY));
   // 50 ns core clock
   always #25 SYS_CLK = ~SYS_CLK;
   // hang guard
   always @(posedge SYS_CLK)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         err_count++;
         give_verdict();
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         err_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // one classic wishbone cycle, held until ack is sampled
   task automatic wb(input logic we, input logic [7:0] a, input logic [3:0] s,
                     input logic [31:0] d, output logic [31:0] q);
      @(posedge SYS_CLK);
      {CYC_I, STB_I, WE_I, ADR_I, SEL_I, DAT_I} <= {2'h3, we, a, s, d};
      // the wait ends once ack is sampled high, or at the hang guard if ack never comes
      do
      begin
         @(posedge SYS_CLK);
      end
      while (ACK_O !== 1'h1);
      q = DAT_O;
      chk(ACK_O, 1'h1);
      {CYC_I, STB_I, WE_I} <= 3'h0;
      DAT_I <= ~d; // released data does not keep its value
   endtask
   task automatic t_reset();
      chk({USER_INT_DISABLE, PRIORITY_LEVEL, STATUS_WORD}, 21'h0);
      wb(1'h0, CPUSR_ADR_STATUS, 4'hF, 32'h0, rd);
      chk(rd, 32'h0);
   endtask
   task automatic t_access();
      wb(1'h1, CPUSR_ADR_STATUS, 4'hF, 32'hFFFF_FFFF, rd);
      wb(1'h0, CPUSR_ADR_STATUS, 4'hF, 32'h0, rd);
      chk(rd, 32'h0000_01EF);
      wb(1'h0, 8'h10, 4'hF, 32'h0, rd);
      chk(rd, 32'h0);
      wb(1'h1, CPUSR_ADR_STATUS, 4'hF, 32'h0, rd);
   endtask
   task automatic t_repeat();
      i_cpusr_core_model.set_repeat(1'h1);
      wb(1'h1, CPUSR_ADR_STATUS, 4'h1, 32'h0, rd);
      wb(1'h0, CPUSR_ADR_STATUS, 4'hF, 32'h0, rd);
      chk(rd, 32'h10);
      i_cpusr_core_model.set_repeat(1'h0);
      repeat (3) @(posedge SYS_CLK);
      chk(STATUS_WORD, 16'h0);
   endtask
   task automatic t_prio();
      wb(1'h1, CPUSR_ADR_STATUS, 4'h1, 32'hE0, rd);
      @(posedge SYS_CLK);
      chk({USER_INT_DISABLE, PRIORITY_LEVEL}, 5'h17);
      wb(1'h1, CPUSR_ADR_INTCTL1, 4'h2, 32'h8000, rd);
      wb(1'h1, CPUSR_ADR_STATUS, 4'h1, 32'h0, rd);
      wb(1'h0, CPUSR_ADR_STATUS, 4'hF, 32'h0, rd);
      chk(rd, 32'hE0);
      wb(1'h1, CPUSR_ADR_INTCTL1, 4'h2, 32'h0, rd);
      wb(1'h1, CPUSR_ADR_STATUS, 4'h1, 32'h60, rd);
      wb(1'h0, CPUSR_ADR_LEVEL, 4'hF, 32'h0, rd);
      chk(rd, 32'h03);
   endtask
   task automatic t_alu();
      logic [15:0] a, b, r;
      logic [4:0]  m, f;
      logic [2:0]  md;
      for (int i = 0; i < 6; i++)
      begin
         {a, b, m, md, f, r} = ALU_TBL[i];
         i_cpusr_core_model.alu_op(a, b, m, md);
         @(posedge SYS_CLK);
         chk({STATUS_WORD[8], STATUS_WORD[3:0]}, f);
         chk(ALU_RESULT, r);
      end
   endtask
   task automatic t_exc();
      wb(1'h1, CPUSR_ADR_STATUS, 4'h1, 32'h45, rd);
      i_cpusr_core_model.exc(8'hA5, 4'hB);
      @(posedge SYS_CLK);
      chk({STACK_WORD_VALID, STACK_WORD}, 17'h1A545);
      chk({USER_INT_DISABLE, PRIORITY_LEVEL}, 5'h1B);
      @(posedge SYS_CLK);
      chk(STACK_WORD_VALID, 1'h0);
      wb(1'h1, CPUSR_ADR_CORECTL, 4'h1, 32'h0, rd);
      wb(1'h0, CPUSR_ADR_LEVEL, 4'hF, 32'h0, rd);
      chk(rd, 32'h03);
   endtask
   // software flag write and alu update committing on the same edge
   task automatic t_race();
      fork
         wb(1'h1, CPUSR_ADR_STATUS, 4'h1, 32'h0F, rd);
         begin
            @(posedge SYS_CLK);
            i_cpusr_core_model.alu_op(16'h0001, 16'h0001, 5'h02, 3'h0);
         end
      join
      @(posedge SYS_CLK);
      chk(STATUS_WORD, 16'h000D);
   endtask
   task automatic give_verdict();
      $display("checks %0d errors %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // main sequence, with a second reset after the race test, before the final reset check
   initial
   begin
      {SYS_CLK, RST_N, CYC_I, STB_I, WE_I, ADR_I, SEL_I, DAT_I} = '0;
      repeat (10) @(posedge SYS_CLK);
      RST_N <= 1'h1;
      t_reset();
      t_access();
      t_repeat();
      t_prio();
      t_alu();
      t_exc();
      t_race();
      RST_N <= 1'h0;
      repeat (2) @(posedge SYS_CLK);
      RST_N <= 1'h1;
      t_reset();
      give_verdict();
   end
endmodule
